//--- pkg/seb_pkg.sv
// Shared constants and types of the serial EEPROM bus front end
package seb_pkg;

    // System clock rate in MHz
    localparam int SEB_CLK_MHZ = 100;

    // Longest internal program cycle, in ms, normal and high supply range
    localparam int SEB_T_WR_MS = 10;
    localparam int SEB_T_WR_FAST_MS = 5;

    // Longest time converted exactly to whole cycles: ms times 1000 times MHz
    localparam int SEB_WR_CYC = SEB_T_WR_MS * 1000 * SEB_CLK_MHZ;
    localparam int SEB_WR_FAST_CYC = SEB_T_WR_FAST_MS * 1000 * SEB_CLK_MHZ;

    // Width of the program cycle counter
    localparam int SEB_CNT_W = 20;

    // Fixed upper five bits of the target address
    localparam logic [4:0] SEB_DEV_TYPE = 5'h14;

    // Bit counter value of the last bit in a byte
    localparam logic [2:0] SEB_LAST_BIT = 3'h7;

    // Number of memory address bytes after the target address
    localparam logic [1:0] SEB_NUM_ADDR_BYTES = 2'h2;

    // Direction bit values
    localparam logic SEB_DIR_READ = 1'b1;

    // Link state machine
    typedef enum logic [3:0] {
        SEB_IDLE = 4'h0,
        SEB_ADDR = 4'h1,
        SEB_ACK = 4'h2,
        SEB_WRITE = 4'h3,
        SEB_TX = 4'h4,
        SEB_MACK = 4'h5,
        SEB_WAIT = 4'h6,
        SEB_PROG = 4'h7
    } seb_state_t;

    // Received byte towards the memory side
    typedef struct packed {
        logic valid;
        logic mem_addr;
        logic [7:0] data;
    } seb_rx_t;

    // Reset value of the received byte carrier
    localparam seb_rx_t SEB_RX_RST = '{valid: 1'b0, mem_addr: 1'b0, data: 8'h00};

endpackage

//--- hw/seb_sync.sv
// Two flip-flop synchroniser for pins entering the system clock domain
`timescale 1ns/1ns
module seb_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_i,
    // Asynchronous inputs and their synchronised copies
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);

    logic [W-1:0] meta_r;

    // First stage feeds only the second stage
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            meta_r <= '0;
            sync_o <= '0;
        end else begin
            meta_r <= async_i;
            sync_o <= meta_r;
        end
    end

endmodule

//--- hw/seb_top.sv
// Bus front end of a serial EEPROM acting as an I2C target
`timescale 1ns/1ns
module seb_top
    import seb_pkg::*;
#(
    parameter int WR_CYC = SEB_WR_CYC,
    parameter int WR_FAST_CYC = SEB_WR_FAST_CYC
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_i,
    // I2C pins, SDA split into in, out and enable
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    // Strap and protect pins
    input wire logic device_select_bit0_i,
    input wire logic device_select_bit1_i,
    input wire logic write_protect_i,
    input wire logic fast_supply_i,
    // Memory side
    output seb_rx_t rx_o,
    input wire logic [7:0] rd_data_i,
    output logic rd_next_o,
    output logic prog_start_o,
    output logic busy_o
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisation and condition detection

    logic [4:0] pins_s;
    logic scl_s;
    logic sda_s;
    logic sel0_s;
    logic sel1_s;
    logic wp_s;
    logic fast_s;
    logic scl_q_r;
    logic sda_q_r;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic addr_match;

    seb_sync #(
        .W(5)
    ) u_sync (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .async_i({fast_supply_i, write_protect_i, device_select_bit1_i,
                  device_select_bit0_i, sda_i}),
        .sync_o(pins_s)
    );

    // Separate synchroniser of the same depth keeps SCL aligned with SDA
    logic scl_s_w;
    seb_sync #(
        .W(1)
    ) u_sync_scl (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .async_i(scl_i),
        .sync_o(scl_s_w)
    );

    assign scl_s = scl_s_w;
    assign sda_s = pins_s[0];
    assign sel0_s = pins_s[1];
    assign sel1_s = pins_s[2];
    assign wp_s = pins_s[3];
    assign fast_s = pins_s[4];

    // Previous sampled levels for edge finding
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            scl_q_r <= 1'b0;
            sda_q_r <= 1'b0;
        end else begin
            scl_q_r <= scl_s;
            sda_q_r <= sda_s;
        end
    end

    assign scl_rise = scl_s && !scl_q_r;
    assign scl_fall = !scl_s && scl_q_r;
    // START detect; SDA moves under SCL high
    assign start_det = scl_s && scl_q_r && sda_q_r && !sda_s;
    assign stop_det = scl_s && scl_q_r && !sda_q_r && sda_s;

    ////////////////////////////////////////////////////////////////////////
    // Link state machine

    seb_state_t state_r;
    logic [7:0] shreg_r;
    logic [2:0] bit_cnt_r;
    logic byte_done_r;
    logic rw_r;
    logic mack_r;
    logic wr_pend_r;
    logic [1:0] byte_idx_r;
    logic [SEB_CNT_W-1:0] prog_cnt_r;

    assign addr_match = (shreg_r[7:3] == SEB_DEV_TYPE) &&
                        (shreg_r[2:1] == {sel1_s, sel0_s});

    // follows controller clock and conditions only outside SEB_PROG
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            state_r <= SEB_IDLE;
            shreg_r <= 8'h00;
            bit_cnt_r <= 3'h0;
            byte_done_r <= 1'b0;
            rw_r <= 1'b0;
            mack_r <= 1'b0;
            wr_pend_r <= 1'b0;
            byte_idx_r <= 2'h0;
            sda_oe_o <= 1'b0;
            rx_o <= SEB_RX_RST;
            rd_next_o <= 1'b0;
            prog_start_o <= 1'b0;
            busy_o <= 1'b0;
            prog_cnt_r <= '0;
        end else begin
            rx_o.valid <= 1'b0;
            rd_next_o <= 1'b0;
            prog_start_o <= 1'b0;
            if (state_r == SEB_PROG) begin
                // bus ignored and SDA released while programming
                sda_oe_o <= 1'b0;
                if (prog_cnt_r == '0) begin
                    state_r <= SEB_IDLE;
                    busy_o <= 1'b0;
                end else begin
                    prog_cnt_r <= prog_cnt_r - 1'b1;
                end
            end else if (start_det) begin
                // START opens address phase from any state but SEB_PROG
                state_r <= SEB_ADDR;
                bit_cnt_r <= 3'h0;
                byte_done_r <= 1'b0;
                byte_idx_r <= 2'h0;
                sda_oe_o <= 1'b0;
            end else if (stop_det) begin
                sda_oe_o <= 1'b0;
                byte_done_r <= 1'b0;
                wr_pend_r <= 1'b0;
                if (wr_pend_r) begin
                    // STOP ending a write launches programming
                    state_r <= SEB_PROG;
                    prog_start_o <= 1'b1;
                    busy_o <= 1'b1;
                    prog_cnt_r <= fast_s ? SEB_CNT_W'(WR_FAST_CYC - 1) :
                                           SEB_CNT_W'(WR_CYC - 1);
                end else begin
                    state_r <= SEB_IDLE;
                end
            end else begin
                case (state_r)
                    SEB_ADDR, SEB_WRITE: begin
                        if (scl_rise) begin
                            shreg_r <= {shreg_r[6:0], sda_s};
                            bit_cnt_r <= bit_cnt_r + 3'h1;
                            if (bit_cnt_r == SEB_LAST_BIT) begin
                                byte_done_r <= 1'b1;
                            end
                        end else if (scl_fall && byte_done_r) begin
                            byte_done_r <= 1'b0;
                            if (state_r == SEB_ADDR) begin
                                if (addr_match) begin
                                    // ack own address on ninth clock
                                    state_r <= SEB_ACK;
                                    sda_oe_o <= 1'b1;
                                    rw_r <= (shreg_r[0] == SEB_DIR_READ);
                                end else begin
                                    // not ours, wait for next START
                                    state_r <= SEB_IDLE;
                                end
                            end else if (byte_idx_r < SEB_NUM_ADDR_BYTES) begin
                                state_r <= SEB_ACK;
                                sda_oe_o <= 1'b1;
                                byte_idx_r <= byte_idx_r + 2'h1;
                                rx_o <= '{valid: 1'b1, mem_addr: 1'b1, data: shreg_r};
                            end else if (wp_s) begin
                                // nack first data byte, no programming
                                state_r <= SEB_WAIT;
                            end else begin
                                state_r <= SEB_ACK;
                                sda_oe_o <= 1'b1;
                                wr_pend_r <= 1'b1;
                                rx_o <= '{valid: 1'b1, mem_addr: 1'b0, data: shreg_r};
                            end
                        end
                    end
                    SEB_ACK: begin
                        // Ack ends at the falling edge of the ninth clock
                        if (scl_fall) begin
                            bit_cnt_r <= 3'h0;
                            if (rw_r) begin
                                state_r <= SEB_TX;
                                shreg_r <= rd_data_i;
                                // drive only for a zero bit
                                sda_oe_o <= !rd_data_i[7];
                            end else begin
                                state_r <= SEB_WRITE;
                                sda_oe_o <= 1'b0;
                            end
                        end
                    end
                    SEB_TX: begin
                        if (scl_rise) begin
                            bit_cnt_r <= bit_cnt_r + 3'h1;
                            if (bit_cnt_r == SEB_LAST_BIT) begin
                                byte_done_r <= 1'b1;
                            end
                        end else if (scl_fall) begin
                            if (byte_done_r) begin
                                // Release for the controller acknowledge
                                byte_done_r <= 1'b0;
                                sda_oe_o <= 1'b0;
                                state_r <= SEB_MACK;
                            end else begin
                                // next bit changes on falling clock
                                shreg_r <= {shreg_r[6:0], 1'b0};
                                sda_oe_o <= !shreg_r[6];
                            end
                        end
                    end
                    SEB_MACK: begin
                        // controller acks our byte on ninth clock
                        if (scl_rise) begin
                            mack_r <= !sda_s;
                            rd_next_o <= !sda_s;
                        end else if (scl_fall) begin
                            bit_cnt_r <= 3'h0;
                            if (mack_r) begin
                                state_r <= SEB_TX;
                                shreg_r <= rd_data_i;
                                sda_oe_o <= !rd_data_i[7];
                            end else begin
                                state_r <= SEB_WAIT;
                            end
                        end
                    end
                    SEB_IDLE, SEB_WAIT: begin
                        // nothing but a START or STOP matters here
                        sda_oe_o <= 1'b0;
                    end
                    default: begin
                        state_r <= SEB_IDLE;
                        sda_oe_o <= 1'b0;
                    end
                endcase
            end
        end
    end

    // output value is always low, only the enable moves
    always_ff @(posedge clk_sys_i) begin
        sda_o <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (reset_i);

    // Helper: cycles spent busy, checked against the longest time
    logic [SEB_CNT_W-1:0] busy_len_r;
    always_ff @(posedge clk_sys_i) begin
        if (reset_i || !busy_o) begin
            busy_len_r <= '0;
        end else begin
            busy_len_r <= busy_len_r + 1'b1;
        end
    end

    sequence seq_addr_done;
        state_r == SEB_ADDR && scl_fall && byte_done_r && !start_det && !stop_det;
    endsequence

    sequence seq_launch;
        stop_det && wr_pend_r && state_r != SEB_PROG;
    endsequence

    AST_OD_LOW: assert property (sda_o == 1'b0)
        else $error("SDA output value not low");

    AST_PROG_QUIET: assert property (busy_o |-> !sda_oe_o)
        else $error("SDA driven during program cycle");

    AST_START_ADDR: assert property ((start_det && state_r != SEB_PROG)
        |=> state_r == SEB_ADDR && !sda_oe_o)
        else $error("START did not open address phase");

    AST_STOP_IDLE: assert property ((stop_det && !wr_pend_r && state_r != SEB_PROG)
        |=> state_r == SEB_IDLE)
        else $error("STOP did not return to idle");

    AST_PROG_LAUNCH: assert property (seq_launch |=> prog_start_o && busy_o ##1
        !prog_start_o && busy_o)
        else $error("Program cycle not launched by STOP");

    AST_PROG_LEN: assert property (busy_o |-> busy_len_r < SEB_CNT_W'(WR_CYC))
        else $error("Program cycle too long");

    AST_WP_BLOCK: assert property ((rx_o.valid && !rx_o.mem_addr)
        |-> !$past(wp_s))
        else $error("Data byte passed while protected");

    AST_ADDR_NOMATCH: assert property ((seq_addr_done and !addr_match)
        |=> state_r == SEB_IDLE && !sda_oe_o)
        else $error("Foreign address acknowledged");

    AST_ADDR_ACK: assert property ((seq_addr_done and addr_match)
        |=> state_r == SEB_ACK && sda_oe_o)
        else $error("Own address not acknowledged");

    AST_DIR_READ: assert property ((state_r == SEB_ACK && rw_r && scl_fall
        && !start_det && !stop_det) |=> state_r == SEB_TX)
        else $error("Read direction did not start transmit");

    AST_DRIVE_ON_FALL: assert property ($rose(sda_oe_o) |-> $past(scl_fall))
        else $error("SDA drive began outside falling clock");

endmodule

//--- tb/seb_bus_ctrl.sv
// Behavioural I2C bus controller facing the front end's bus pins
`timescale 1ns/1ns
module seb_bus_ctrl (
    // Clock and resolved data line
    input wire logic clk_sys_i,
    input wire logic sda_i,
    // Bus clock and data pull-down
    output logic scl_o,
    output logic sda_pull_o
);
    // Idle bus: clock high, data released to the pull-up
    initial begin
        scl_o = 1'b1;
        sda_pull_o = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask

    // data falls while clock high, repeated too
    task automatic start();
        sda_pull_o <= 1'b0;
        tick(4);
        scl_o <= 1'b1;
        tick(8);
        sda_pull_o <= 1'b1;
        tick(8);
        scl_o <= 1'b0;
        tick(4);
    endtask

    // end in a stop, then leave the bus free
    task automatic stop();
        sda_pull_o <= 1'b1;
        tick(4);
        scl_o <= 1'b1;
        tick(8);
        sda_pull_o <= 1'b0;
        tick(16);
    endtask

    // data only moves while clock low
    // Sampled on a falling edge of clk_sys_i while SCL is high, so the device's update has landed
    task automatic bit_io(input logic b, output logic seen);
        sda_pull_o <= !b;
        tick(4);
        scl_o <= 1'b1;
        tick(4);
        @(negedge clk_sys_i);
        seen = sda_i;
        tick(4);
        scl_o <= 1'b0;
        tick(4);
    endtask

    // ninth clock carries the acknowledge, MSB first before it
    task automatic byte_io(input logic [7:0] tx, input logic ninth, output logic [7:0] rx,
                           output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], s);
            rx[i] = s;
        end
        bit_io(ninth, s);
        ack = !s;
    endtask
endmodule

//--- tb/tb.sv
// Self-checking bench of the serial EEPROM bus front end
`timescale 1ns/1ns
module tb;
    import seb_pkg::*;
    // Shortened program times keep the run brief
    localparam int WR = 2000;
    localparam int WRF = 1000;
    logic clk_sys_i = 1'b0;
    logic reset_i = 1'b1;
    logic sda_o, sda_oe_o, rd_next_o, prog_start_o, busy_o, scl, pull;
    logic dsel0 = 1'b0, dsel1 = 1'b0, wp = 1'b0, fast = 1'b0;
    logic [7:0] rd_data = 8'h00;
    logic [7:0] tmp;
    seb_rx_t rx_o;
    // Open-drain wire with pull-up
    wire logic sda = !(pull || sda_oe_o);
    int num_errors = 0, checked = 0, seed = 94467, cyc = 0;
    int busy_cnt = 0, prog_cnt = 0, bad_cnt = 0, next_cnt = 0;
    logic [8:0] got_q[$], exp_q[$];
    logic [7:0] rd_q[$];

    seb_top #(.WR_CYC(WR), .WR_FAST_CYC(WRF)) u_seb_top (
        .clk_sys_i(clk_sys_i), .reset_i(reset_i), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe_o(sda_oe_o), .device_select_bit0_i(dsel0),
        .device_select_bit1_i(dsel1), .write_protect_i(wp), .fast_supply_i(fast),
        .rx_o(rx_o), .rd_data_i(rd_data), .rd_next_o(rd_next_o),
        .prog_start_o(prog_start_o), .busy_o(busy_o));

    seb_bus_ctrl u_seb_bus_ctrl (.clk_sys_i(clk_sys_i), .sda_i(sda), .scl_o(scl),
        .sda_pull_o(pull));

    always #5 clk_sys_i = ~clk_sys_i;

    ////////////////////////////////////////////////////////////////////////////
    // Memory-side monitor, read data source and hang guard
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (rx_o.valid === 1'b1) got_q.push_back({rx_o.mem_addr, rx_o.data});
        if (busy_o === 1'b1) busy_cnt <= busy_cnt + 1;
        if (prog_start_o === 1'b1) prog_cnt <= prog_cnt + 1;
        // only ever pulls low, silent while programming
        // Reset cycles skipped: outputs are unknown before the first edge
        if (!reset_i && ((busy_o && sda_oe_o) || sda_o !== 1'b0)) bad_cnt <= bad_cnt + 1;
        if (rd_next_o === 1'b1) begin
            next_cnt <= next_cnt + 1;
            tmp = 8'($random(seed));
            rd_data <= tmp;
            rd_q.push_back(tmp);
        end
        if (cyc == 40000) begin
            num_errors++;
            report_and_stop();
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic addr_byte(input logic [7:0] a, output logic ack);
        logic [7:0] rx;
        u_seb_bus_ctrl.start();
        u_seb_bus_ctrl.byte_io(a, 1'b1, rx, ack);
    endtask

    task automatic check_rx();
        check("rx count", got_q.size(), exp_q.size());
        foreach (exp_q[i]) check("rx byte", got_q[i], exp_q[i]);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Write of n data bytes, then a poll during the program cycle
    task automatic write_test(input logic fst, input logic prot, input int n);
        logic ack;
        logic in_range;
        logic [7:0] b, rx;
        got_q = {};
        exp_q = {};
        {dsel1, dsel0} <= 2'($random(seed));
        fast <= fst;
        wp <= prot;
        u_seb_bus_ctrl.tick(6);
        addr_byte({SEB_DEV_TYPE, dsel1, dsel0, 1'b0}, ack);
        check("addr ack", ack, 1);
        for (int i = 0; i < n + 2; i++) begin
            b = 8'($random(seed));
            u_seb_bus_ctrl.byte_io(b, 1'b1, rx, ack);
            check("byte ack", ack, !(prot && i >= 2));
            if (prot && i >= 2) break;
            exp_q.push_back({i < 2, b});
        end
        busy_cnt = 0;
        prog_cnt = 0;
        u_seb_bus_ctrl.stop();
        check("prog start", prog_cnt, !prot);
        addr_byte({SEB_DEV_TYPE, dsel1, dsel0, 1'b0}, ack);
        check("poll ack", ack, prot);
        u_seb_bus_ctrl.stop();
        for (int k = 0; k < 3 * WR && busy_o !== 1'b0; k++) u_seb_bus_ctrl.tick(1);
        // program time bounded by supply range
        in_range = busy_cnt <= (fst ? WRF : WR) && busy_cnt > (fst ? 0 : WRF);
        check("busy time", in_range, !prot);
        check_rx();
        check("open drain", bad_cnt, 0);
        wp <= 1'b0;
        $display("write test done fast %0b protect %0b", fst, prot);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Dummy write of the address, repeated start, sequential read
    task automatic read_test(input int n);
        logic ack;
        logic [7:0] b, rx;
        got_q = {};
        exp_q = {};
        b = 8'($random(seed));
        rd_data <= b;
        rd_q = {b};
        next_cnt = 0;
        addr_byte({SEB_DEV_TYPE, dsel1, dsel0, 1'b0}, ack);
        for (int i = 0; i < 2; i++) begin
            b = 8'($random(seed));
            u_seb_bus_ctrl.byte_io(b, 1'b1, rx, ack);
            exp_q.push_back({1'b1, b});
        end
        addr_byte({SEB_DEV_TYPE, dsel1, dsel0, SEB_DIR_READ}, ack);
        check("read addr ack", ack, 1);
        for (int i = 0; i < n; i++) begin
            u_seb_bus_ctrl.byte_io(8'hFF, i == n - 1, rx, ack);
            check("read byte", rx, rd_q[i]);
        end
        u_seb_bus_ctrl.stop();
        check("next pulses", next_cnt, n - 1);
        check_rx();
        $display("read test done");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        logic ack;
        repeat (4) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        u_seb_bus_ctrl.tick(6);
        // Every select field value against a random strap setting, plus a wrong type field at k = 4
        for (int k = 0; k < 5; k++) begin
            {dsel1, dsel0} <= 2'($random(seed));
            u_seb_bus_ctrl.tick(6);
            addr_byte({(k == 4) ? 5'h15 : SEB_DEV_TYPE, 2'(k), 1'b0}, ack);
            check("strap ack", ack, k == {dsel1, dsel0});
            u_seb_bus_ctrl.stop();
        end
        $display("strap test done");
        write_test(1'b0, 1'b0, 2);
        write_test(1'b1, 1'b0, 1);
        write_test(1'b0, 1'b1, 2);
        read_test(3);
        report_and_stop();
    end
endmodule
